// ### common/pxl_cfg.svh
// pxl_cfg.svh: offsets, field positions and reset values of the crossover
// and loopback control registers.
// assumes: included by its bare name wherever these constants are needed.
`ifndef PXL_CFG_SVH
`define PXL_CFG_SVH

// register addresses on the management interface (5-bit address)
`define PXL_ADDR_XOVER 5'h12
`define PXL_ADDR_LOOP 5'h13
`define PXL_ADDR_RXERR 5'h14

// crossover_and_error_select field positions
`define PXL_XO_RESOLVE 15
`define PXL_XO_CNT_FC 14
`define PXL_XO_CNT_SYM 13
`define PXL_XO_AUTO 10
`define PXL_XO_MANUAL_X 9
`define PXL_XO_DIAG 2
`define PXL_XO_MASK 16'hE604
`define PXL_XO_RESET 16'h8400

// loopback_select field positions
`define PXL_LB_MII 15
`define PXL_LB_DIGITAL 12
`define PXL_LB_DRIVER 10
`define PXL_LB_REMOTE 9
`define PXL_LB_CABLE 7
`define PXL_LB_TX_SUPP 6
`define PXL_LB_FORCE_LINK 0
`define PXL_LB_MASK 16'h96C1
`define PXL_LB_RESET 16'h1041

// receive error counter reset value
`define PXL_RXERR_RESET 16'h0000

`endif

// ### common/pxl_pkg.sv
// pxl_pkg.sv: types shared by the crossover and loopback control block.
// assumes: pxl_cfg.svh supplies the numeric constants.
package pxl_pkg;

  // speed of the link as resolved elsewhere in the transceiver
  typedef enum logic [1:0] {
    PXL_SPEED_10 = 2'h0,
    PXL_SPEED_100 = 2'h1,
    PXL_SPEED_1000 = 2'h2
  } pxl_speed_t;

  // one-hot sequencing of a forced speed request
  typedef enum logic [2:0] {
    PXL_ST_IDLE = 3'h1,
    PXL_ST_RESOLVE = 3'h2,
    PXL_ST_APPLY = 3'h4
  } pxl_state_t;

  // role of one line pair: transmit channel and receive channel (A..D = 0..3)
  typedef struct packed {
    logic used;
    logic [1:0] tx_chan;
    logic [1:0] rx_chan;
  } pxl_pair_t;

  // receive error events from the data path
  typedef struct packed {
    logic crc_err;
    logic symbol_err;
    logic false_carrier;
  } pxl_err_t;

  // loopback controls handed to the data path
  typedef struct packed {
    logic mii;
    logic digital;
    logic driver;
    logic remote;
    logic cable;
    logic tx_suppress;
  } pxl_loop_t;

endpackage

// ### hw/pxl_ctrl.sv
// pxl_ctrl.sv: crossover, receive error selection and loopback control
// registers of the transceiver, with the pair mapping they steer.
// assumes: a management interface front end hands one-cycle read and write
// strobes with a 5-bit register address, synchronous to clock_i.
`timescale 1ns/1ns
`include "pxl_cfg.svh"

module pxl_ctrl
  import pxl_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // management register access
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // link state from the rest of the transceiver
  input wire pxl_speed_t speed_i,
  input wire logic link_up_i,
  input wire logic auto_is_x_i,
  input wire logic cd_swapped_i,
  input wire logic force_speed_i,
  input wire logic xover_done_i,
  input wire pxl_err_t err_i,
  input wire logic loopback_main_i,
  // controls to the rest of the transceiver
  output pxl_pair_t [3:0] line_pair_o,
  output logic mdix_o,
  output logic resolving_o,
  output logic speed_apply_o,
  output logic diag_en_o,
  output pxl_loop_t loop_o,
  output logic line_tx_en_o,
  output logic link_status_o,
  output logic [15:0] rx_err_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // both control words keep only their defined bits, so reserved
  // positions read back zero whatever software wrote

  logic [15:0] xover;
  logic [15:0] loopback;
  logic [15:0] rx_err;
  pxl_state_t state;
  pxl_state_t next_state;
  logic next_mdix;
  pxl_pair_t [3:0] next_pair;
  logic next_link;
  logic count_hit;
  logic [15:0] next_rx_err;

  // build one pair role
  function automatic pxl_pair_t pair_role(input logic used,
                                          input logic [1:0] tx,
                                          input logic [1:0] rx);
    pair_role = '{used: used, tx_chan: tx, rx_chan: rx};
  endfunction

  // one strobe aimed at one register; writes and the clear on read decode
  // through here, while the read data mux decodes addr_i in its own case statement
  function automatic logic addr_hit(input logic strobe,
                                    input logic [4:0] addr,
                                    input logic [4:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  // write crossover register; reserved bits never stored
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      xover <= `PXL_XO_RESET;
    end else if (addr_hit(wr_en_i, addr_i, `PXL_ADDR_XOVER)) begin
      xover <= wdata_i & `PXL_XO_MASK;
    end
  end

  // write loopback register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loopback <= `PXL_LB_RESET;
    end else if (addr_hit(wr_en_i, addr_i, `PXL_ADDR_LOOP)) begin
      loopback <= wdata_i & `PXL_LB_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive error counter

  // base type chosen by the symbol bit, false carrier added on top
  always_comb begin
    count_hit = xover[`PXL_XO_CNT_SYM] ? err_i.symbol_err
                                       : err_i.crc_err;
    if (xover[`PXL_XO_CNT_FC] && err_i.false_carrier) begin
      count_hit = 1'b1;
    end
  end

  // next counter value: saturates rather than wrapping, so a flood of
  // errors between two reads still reads back as many, never as few.
  // a read clears it; an event in the same cycle as the read is kept as
  // the new first count so no error slips between two reads
  always_comb begin
    if (addr_hit(rd_en_i, addr_i, `PXL_ADDR_RXERR)) begin
      next_rx_err = {15'h0000, count_hit};
    end else if (count_hit && rx_err != 16'hFFFF) begin
      next_rx_err = rx_err + 16'h0001;
    end else begin
      next_rx_err = rx_err;
    end
  end

  // counter itself; only the device clears it, writes never reach it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_err <= `PXL_RXERR_RESET;
    end else begin
      rx_err <= next_rx_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port; unmapped addresses read zero. the answer comes one
  // cycle after the strobe with rvalid, and rdata holds until the next read
  // so a slow station may still pick it up later

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        case (addr_i)
          `PXL_ADDR_XOVER: rdata_o <= xover;
          `PXL_ADDR_LOOP: rdata_o <= loopback;
          `PXL_ADDR_RXERR: rdata_o <= rx_err;
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced speed sequencing

  // a forced speed waits for crossover to settle only when asked to.
  // with manual crossover there is nothing to settle, so the wait ends at
  // once. limitation: a request that arrives while one is still in flight
  // is dropped; the station must wait for speed_apply_o before repeating
  always_comb begin
    next_state = state;
    case (state)
      PXL_ST_IDLE: begin
        if (force_speed_i) begin
          next_state = xover[`PXL_XO_RESOLVE] ? PXL_ST_RESOLVE
                                              : PXL_ST_APPLY;
        end
      end
      PXL_ST_RESOLVE: begin
        if (xover_done_i || !xover[`PXL_XO_AUTO]) begin
          next_state = PXL_ST_APPLY;
        end
      end
      PXL_ST_APPLY: begin
        next_state = PXL_ST_IDLE;
      end
      default: begin
        next_state = PXL_ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= PXL_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // strobes decoded from the next state so they line up with the state
  // register instead of trailing it by a cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      resolving_o <= 1'b0;
      speed_apply_o <= 1'b0;
    end else begin
      resolving_o <= (next_state == PXL_ST_RESOLVE);
      speed_apply_o <= (next_state == PXL_ST_APPLY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossover and pair mapping

  // auto detection overrides the manual bit; C/D swap corrected at 1000 speed only.
  // the swap detector runs in both modes, since a manual MDI-X setting
  // says nothing about how pairs C and D were wired at the far end
  always_comb begin
    next_mdix = xover[`PXL_XO_AUTO] ? auto_is_x_i
                                    : xover[`PXL_XO_MANUAL_X];
    if (speed_i == PXL_SPEED_1000) begin
      if (!next_mdix) begin
        next_pair[0] = pair_role(1'b1, 2'h0, 2'h1);
        next_pair[1] = pair_role(1'b1, 2'h1, 2'h0);
      end else begin
        next_pair[0] = pair_role(1'b1, 2'h1, 2'h0);
        next_pair[1] = pair_role(1'b1, 2'h0, 2'h1);
      end
      // cd_swapped flips C and D roles on pairs 2 and 3
      if (next_mdix ^ cd_swapped_i) begin
        next_pair[2] = pair_role(1'b1, 2'h3, 2'h2);
        next_pair[3] = pair_role(1'b1, 2'h2, 2'h3);
      end else begin
        next_pair[2] = pair_role(1'b1, 2'h2, 2'h3);
        next_pair[3] = pair_role(1'b1, 2'h3, 2'h2);
      end
    end else begin
      // 10/100: one pair each way, tx and rx both on channel A.
      // limitation: used marks the transmitting pair only; the receiving
      // pair is the other one of pairs 0 and 1
      next_pair[0] = pair_role(1'b1, next_mdix ? 2'h0 : 2'h0, 2'h0);
      next_pair[1] = pair_role(1'b1, 2'h0, 2'h0);
      next_pair[0].used = !next_mdix; // pair 0 transmits in MDI
      next_pair[1].used = next_mdix; // pair 1 transmits in MDI-X
      next_pair[2] = pair_role(1'b0, 2'h0, 2'h0);
      next_pair[3] = pair_role(1'b0, 2'h0, 2'h0);
    end
  end

  // effective crossover setting as reported to the rest of the transceiver
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mdix_o <= 1'b0;
    end else begin
      mdix_o <= next_mdix;
    end
  end

  // pair roles; registered so the analog side never sees a half-changed
  // mapping while speed and crossover move in the same cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      line_pair_o <= '0;
    end else begin
      line_pair_o <= next_pair;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loopback, diagnostics and link status

  // MII loopback reports the forced value; other modes follow the link.
  // the forced value also needs the main loopback bit, loopback_main_i, to be set
  always_comb begin
    if (loopback_main_i && loopback[`PXL_LB_MII]) begin
      next_link = loopback[`PXL_LB_FORCE_LINK];
    end else begin
      next_link = link_up_i;
    end
  end

  // loopback selections to the data path, one cycle behind the register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loop_o <= '0;
    end else begin
      loop_o.mii <= loopback[`PXL_LB_MII];
      loop_o.digital <= loopback[`PXL_LB_DIGITAL];
      loop_o.driver <= loopback[`PXL_LB_DRIVER];
      loop_o.remote <= loopback[`PXL_LB_REMOTE];
      loop_o.cable <= loopback[`PXL_LB_CABLE];
      loop_o.tx_suppress <= loopback[`PXL_LB_TX_SUPP];
    end
  end

  // line transmit gate; suppression only bites in digital loopback, every
  // other mode leaves the line driver running
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      line_tx_en_o <= 1'b0;
    end else begin
      line_tx_en_o <= !(loopback[`PXL_LB_DIGITAL]
                        && loopback[`PXL_LB_TX_SUPP]);
    end
  end

  // diagnostics gate; keeping it off while a link is up is left to
  // software, since link analysis runs without it anyway
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      diag_en_o <= 1'b0;
    end else begin
      diag_en_o <= xover[`PXL_XO_DIAG];
    end
  end

  // link status as reported to the controller
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link_status_o <= 1'b0;
    end else begin
      link_status_o <= next_link;
    end
  end

  // counter copy for the data path, trailing the counter by one cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_err_count_o <= `PXL_RXERR_RESET;
    end else begin
      rx_err_count_o <= rx_err;
    end
  end

endmodule // pxl_ctrl

// ### testbench/pxl_ctrl_asserts.sv
// pxl_ctrl_asserts.sv: port timing checks for the control block.
// assumes: bound to pxl_ctrl, input names match its ports.
`timescale 1ns/1ns
`include "pxl_cfg.svh"
module pxl_ctrl_asserts
  import pxl_pkg::*;
(
  // clock, reset, bus
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic rd_en_i,
  input wire logic [4:0] addr_i,
  // link side
  input wire pxl_speed_t speed_i,
  input wire logic link_up_i,
  input wire logic force_speed_i,
  input wire logic xover_done_i,
  input wire pxl_err_t err_i,
  input wire pxl_pair_t [3:0] line_pair_o,
  input wire logic resolving_o,
  input wire logic speed_apply_o,
  input wire pxl_loop_t loop_o,
  input wire logic line_tx_en_o,
  input wire logic link_status_o,
  input wire logic [15:0] rx_err_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////////
  // forced speed: applied only on request, soon after crossover settles
  property p_apply; $rose(speed_apply_o) |-> $past(force_speed_i) ||
    $past(resolving_o) || $past(resolving_o, 2); endproperty
  a_apply: assert property (p_apply) else $error("stray apply");
  property p_wait; resolving_o && xover_done_i |-> ##[1:2] speed_apply_o;
  endproperty
  a_wait: assert property (p_wait) else $error("late apply");
  // two settled cycles, since outputs lag the register by one
  property p_supp; (loop_o.digital && loop_o.tx_suppress)[*2] |->
    !line_tx_en_o; endproperty
  a_supp: assert property (p_supp) else $error("tx not held");
  property p_link; (!loop_o.mii && $stable(link_up_i))[*2] |->
    link_status_o == link_up_i; endproperty
  a_link: assert property (p_link) else $error("link wrong");
  // pair roles once the speed has stood long enough to be registered
  property p_p10; !$past(reset_i) && speed_i != PXL_SPEED_1000 &&
    $stable(speed_i) |-> !line_pair_o[2].used && !line_pair_o[3].used;
  endproperty
  a_p10: assert property (p_p10) else $error("pair 2/3 used");
  property p_p1g; (speed_i == PXL_SPEED_1000)[*3] |->
    line_pair_o[0].tx_chan == line_pair_o[1].rx_chan &&
    !line_pair_o[0].tx_chan[1]; endproperty
  a_p1g: assert property (p_p1g) else $error("gig pairs");
  // counter copy trails the count by one cycle
  property p_idle; !$past(rd_en_i) && $past(err_i) == 3'h0 |=>
    $stable(rx_err_count_o); endproperty
  a_idle: assert property (p_idle) else $error("count moved");
  property p_clr; rd_en_i && addr_i == `PXL_ADDR_RXERR |-> ##2
    rx_err_count_o <= 16'h0001; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  c_wait: cover property (resolving_o && xover_done_i);
  c_mii: cover property (loop_o.mii && link_status_o);
  c_clr: cover property (rd_en_i && addr_i == `PXL_ADDR_RXERR);
endmodule // pxl_ctrl_asserts
bind pxl_ctrl pxl_ctrl_asserts u_chk (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .rd_en_i(rd_en_i),
  .addr_i(addr_i),
  .speed_i(speed_i),
  .link_up_i(link_up_i),
  .force_speed_i(force_speed_i),
  .xover_done_i(xover_done_i),
  .err_i(err_i),
  .line_pair_o(line_pair_o),
  .resolving_o(resolving_o),
  .speed_apply_o(speed_apply_o),
  .loop_o(loop_o),
  .line_tx_en_o(line_tx_en_o),
  .link_status_o(link_status_o),
  .rx_err_count_o(rx_err_count_o)
);

// ### testbench/pxl_mgmt_model.sv
// pxl_mgmt_model.sv: management station issuing one-cycle strobes.
// assumes: bench calls wr and rd; the block samples on rising edges.
`timescale 1ns/1ns
module pxl_mgmt_model (
  // clock and read return
  input wire logic clock_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  // requests toward the block
  output logic wr_en_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [4:0] addr_o = 5'h00,
  output logic [15:0] wdata_o = 16'h0000,
  output logic main_lb_o = 1'b0
);
  //////////////////////////////////////////////////////////////////////////
  // write, then scramble the idle bus so stale values cannot pass
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock_i);
    {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clock_i);
    {wr_en_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    if (a == 5'h13) main_lb_o = |(d & 16'h9400);
  endtask
  // read data only counts while rvalid stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock_i);
    {rd_en_o, addr_o} = {1'b1, a};
    @(negedge clock_i);
    {rd_en_o, addr_o} = {1'b0, ~a};
    d = rvalid_i ? rdata_i : 16'hXXXX;
  endtask
endmodule // pxl_mgmt_model

// ### testbench/tb_pxl_ctrl.sv
// tb_pxl_ctrl.sv: self-checking bench for the crossover and loopback block.
// assumes: pxl_mgmt_model makes the strobes; the checker is bound.
`timescale 1ns/1ns
`include "pxl_cfg.svh"
module tb_pxl_ctrl;
  import pxl_pkg::*;
  logic clock_i = 1'b0, reset_i = 1'b1, wr_en_i, rd_en_i, rvalid_o, mdix_o;
  logic resolving_o, speed_apply_o, diag_en_o, line_tx_en_o, link_status_o;
  logic link_up_i = 1'b0, auto_is_x_i = 1'b0, cd_swapped_i = 1'b0, mx;
  logic force_speed_i = 1'b0, xover_done_i = 1'b0, loopback_main_i;
  logic [4:0] addr_i;
  logic [15:0] wdata_i, rdata_o, rx_err_count_o, d, e;
  pxl_speed_t speed_i = PXL_SPEED_10;
  pxl_err_t err_i = 3'h0;
  pxl_pair_t [3:0] line_pair_o;
  pxl_loop_t loop_o;
  logic [15:0] lbv [7] = '{16'h8001, 16'h8000, 16'h1041, 16'h1001,
    16'h0400, 16'h0200, 16'h0080};
  int miscompares = 0, n_checks = 0, cycles = 0, seed = 32'h75E4919F;
  int i, j, n;
  pxl_ctrl DUT (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .speed_i(speed_i),
    .link_up_i(link_up_i),
    .auto_is_x_i(auto_is_x_i),
    .cd_swapped_i(cd_swapped_i),
    .force_speed_i(force_speed_i),
    .xover_done_i(xover_done_i),
    .err_i(err_i),
    .loopback_main_i(loopback_main_i),
    .line_pair_o(line_pair_o),
    .mdix_o(mdix_o),
    .resolving_o(resolving_o),
    .speed_apply_o(speed_apply_o),
    .diag_en_o(diag_en_o),
    .loop_o(loop_o),
    .line_tx_en_o(line_tx_en_o),
    .link_status_o(link_status_o),
    .rx_err_count_o(rx_err_count_o)
  );
  pxl_mgmt_model m (.clock_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .main_lb_o(loopback_main_i));
  //////////////////////////////////////////////////////////////////////////
  // clock, and a hang limit far above the run's length
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle();
    repeat (2) @(negedge clock_i);
  endtask
  // gigabit roles of pair j: tx channel then rx channel
  function automatic logic [3:0] gig(int j, logic x, logic sw);
    j = j ^ int'(j > 1 && sw);
    return {2'(j ^ x), 2'(j ^ !x)};
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    settle();
    reset_i = 1'b0;
    m.rd(`PXL_ADDR_XOVER, d);
    chk("xo", d, 16'h8400);
    m.rd(`PXL_ADDR_LOOP, d);
    chk("lb", d, 16'h1041);
    chk("loop", 16'(loop_o), 16'h0011);
    $display("reset test done");
    // random writes; link stays down while diagnostics may be set
    for (i = 0; i < 8; i++) begin
      e = 16'($random(seed));
      m.wr(`PXL_ADDR_LOOP, e);
      m.wr(`PXL_ADDR_XOVER, e);
      m.rd(`PXL_ADDR_LOOP, d);
      chk("lb", d, e & 16'h96C1);
      m.rd(`PXL_ADDR_XOVER, d);
      chk("xo", d, e & 16'hE604);
      chk("loop", 16'(loop_o), {e[15], e[12], e[10:9], e[7:6]});
      chk("diag", diag_en_o, e[2]);
    end
    m.rd(5'h03, d);
    chk("hole", d, 16'h0000);
    $display("register test done");
    // crossover: auto or manual, every speed, C/D swap or not
    for (i = 0; i < 32; i++) begin
      e = 16'($random(seed));
      {cd_swapped_i, auto_is_x_i} = e[1:0];
      speed_i = pxl_speed_t'(e[3:2] % 2'h3);
      m.wr(`PXL_ADDR_XOVER, e & 16'h0600);
      settle();
      mx = e[10] ? e[0] : e[9];
      chk("mdix", mdix_o, mx);
      for (j = 0; j < 4; j++)
        if (speed_i == PXL_SPEED_1000)
          chk("gig", line_pair_o[j][3:0], gig(j, mx, e[1]));
        else
          chk("used", line_pair_o[j].used, j < 2 && j[0] == mx);
    end
    $display("crossover test done");
    // forced speed with and without settling crossover first
    for (i = 0; i < 2; i++) begin
      m.wr(`PXL_ADDR_XOVER, i ? 16'h0400 : 16'h8400);
      settle();
      force_speed_i = 1'b1;
      @(negedge clock_i);
      force_speed_i = 1'b0;
      chk("force", {resolving_o, speed_apply_o}, i ? 2'b01 : 2'b10);
      settle();
      xover_done_i = 1'b1;
      for (n = 0; n < 4 && speed_apply_o !== 1'b1 && !i; n++)
        @(negedge clock_i);
      chk("apply", speed_apply_o, !i);
      xover_done_i = 1'b0;
    end
    $display("forced speed test done");
    // error counter under each pairing of the selection bits
    for (i = 0; i < 4; i++) begin
      m.wr(`PXL_ADDR_XOVER, {1'b0, 2'(i), 13'h0400});
      m.rd(`PXL_ADDR_RXERR, d);
      n = 0;
      repeat (24) begin
        err_i = pxl_err_t'(3'($random(seed)));
        n += (err_i.false_carrier & i[1]) |
          (i[0] ? err_i.symbol_err : err_i.crc_err);
        @(negedge clock_i);
      end
      err_i = 3'h0;
      m.wr(`PXL_ADDR_RXERR, 16'hFFFF);
      chk("copy", rx_err_count_o, 16'(n));
      m.rd(`PXL_ADDR_RXERR, d);
      chk("count", d, 16'(n));
    end
    $display("counter test done");
    // loopback modes, link from the line or forced under mii
    for (i = 0; i < 7; i++) begin
      link_up_i = 1'($random(seed));
      m.wr(`PXL_ADDR_LOOP, lbv[i]);
      settle();
      chk("txen", line_tx_en_o, !(lbv[i][12] && lbv[i][6]));
      chk("link", link_status_o, lbv[i][15] ? lbv[i][0] : link_up_i);
    end
    $display("loopback test done");
    end_sim();
  end
endmodule // tb_pxl_ctrl
